//--- shared/dac_host_defs.svh
`ifndef DAC_HOST_DEFS_SVH
`define DAC_HOST_DEFS_SVH

// ---------------------------------------------------------------
// Register offsets (byte addresses, one word each)
// ---------------------------------------------------------------
`define OFS_CTRL        8'h00
`define OFS_CODE_A      8'h04
`define OFS_CODE_B      8'h08
`define OFS_CMD         8'h0c
`define OFS_STATUS      8'h10

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define CTRL_PAR_BIT    0
`define CMD_GO_A_BIT    0
`define CMD_GO_B_BIT    1
`define CMD_LOAD_BIT    2
`define STAT_BUSY_BIT   0
`define STAT_REFUSE_BIT 1
`define STAT_PEND_LSB   4
`define CODE_MSB        11

// ---------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------
`define RST_CTRL_PAR    1'b0
`define RST_CODE        12'h000

// ---------------------------------------------------------------
// Timing, in ns, and derived cycle counts (least times round up)
// ---------------------------------------------------------------
`define T_CLK_NS        100
`define T_SETUP_NS      100
`define T_STROBE_NS     200
`define T_HOLD_NS       100
`define T_LOAD_NS       200
`define SETUP_CYC       ((`T_SETUP_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define STROBE_CYC      ((`T_STROBE_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define HOLD_CYC        ((`T_HOLD_NS + `T_CLK_NS - 1) / `T_CLK_NS)
`define LOAD_CYC        ((`T_LOAD_NS + `T_CLK_NS - 1) / `T_CLK_NS)

`endif

//--- shared/dac_host_pkg.sv
package dac_host_pkg;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_SETUP  = 3'b001,
    ST_STROBE = 3'b010,
    ST_HOLD   = 3'b011,
    ST_LOAD   = 3'b100
  } phase_type;

  typedef struct packed {
    logic        ctrl_par;
    logic [11:0] code_a;
    logic [11:0] code_b;
    logic        refused;
    logic [31:0] prdata;
    phase_type   state;
    logic [3:0]  pend;
    logic        both;
    logic        do_load;
    logic [1:0]  step;
    logic [11:0] dac_data;
    logic        sel_low;
    logic        sel_high;
    logic        cs_n;
    logic        wr_n;
    logic        converter_load_strobe_n_n;
    logic        a_n;
    logic        b_n;
  } host_state_type;

  typedef struct packed {
    logic [3:0] cnt;
  } timer_state_type;

endpackage

//--- verification/dac_device_model.sv
`timescale 1ns/10ps
`default_nettype none

module dac_device_model (
  input  wire logic        clk,      // Core clock
  input  wire logic        rst_n,    // Reset, active low
  input  wire logic [11:0] data,     // Data lines
  input  wire logic [1:0]  sel,      // Latch address
  input  wire logic [4:0]  ctl_n,    // Chip, write, load, A, B strobes
  output logic      [11:0] dac_a,    // Converter A latch
  output logic      [11:0] dac_b,    // Converter B latch
  output logic      [23:0] pend,     // Input latches, B over A
  output logic      [7:0]  both_cnt, // Joint writes seen
  output logic      [7:0]  load_cnt  // Load edges seen
);
  // ---------------------------------------------
  // Pin sampling, all pins together
  // ---------------------------------------------
  logic [18:0] s1;
  logic [18:0] s2;
  logic [18:0] pv;
  logic        wr_rise;

  assign wr_rise = !pv[3] && s2[3];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1 <= '1;
      s2 <= '1;
      pv <= '1;
      dac_a <= 12'h000;
      dac_b <= 12'h000;
      pend <= 24'h000000;
      both_cnt <= 8'h00;
      load_cnt <= 8'h00;
    end else begin
      s1 <= {data, sel, ctl_n};
      s2 <= s1;
      pv <= s2;
      if (wr_rise && !pv[4]) begin
        case (pv[6:5])
          2'd0: pend[7:0] <= pv[14:7];
          2'd1: pend[11:8] <= pv[10:7];
          2'd2: pend[19:12] <= pv[14:7];
          default: pend[23:20] <= pv[10:7];
        endcase
      end
      if (pv[2] && !s2[2]) begin
        dac_a <= pend[11:0];
        dac_b <= pend[23:12];
        load_cnt <= load_cnt + 8'h01;
      end
      // Transparent while strobe and select are low
      if (!s2[3] && !s2[1]) dac_a <= s2[18:7];
      if (!s2[3] && !s2[0]) dac_b <= s2[18:7];
      if (wr_rise && !pv[1]) dac_a <= pv[18:7];
      if (wr_rise && !pv[0]) dac_b <= pv[18:7];
      if (wr_rise && !pv[1] && !pv[0]) both_cnt <= both_cnt + 8'h01;
    end
  end
endmodule

`default_nettype wire

//--- verification/dac_host_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "dac_host_defs.svh"

module dac_host_bench;
  logic        clk;
  logic        rstn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  wire  [31:0] prdata;
  wire         pready;
  wire         pslverr;
  wire  [11:0] dac_data;
  wire         sel_lo;
  wire         sel_hi;
  wire         cs_n;
  wire         wr_n;
  wire         ld_n;
  wire         a_n;
  wire         b_n;
  wire  [11:0] dac_a;
  wire  [11:0] dac_b;
  wire  [23:0] pend;
  wire  [7:0]  both_cnt;
  wire  [7:0]  load_cnt;
  int          mismatches;
  int          checks_done;
  logic [31:0] q;
  logic        e;

  dac_host u_dut (
    .CLK(clk), .RSTN(rstn), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .DAC_DATA(dac_data), .LATCH_SELECT_LOW(sel_lo), .LATCH_SELECT_HIGH(sel_hi),
    .CHIP_SELECT_N(cs_n), .WRITE_STROBE_N(wr_n), .CONVERTER_LOAD_STROBE_N(ld_n),
    .CHANNEL_A_SELECT_N(a_n), .CHANNEL_B_SELECT_N(b_n)
  );

  dac_device_model u_dev (
    .clk(clk), .rst_n(rstn), .data(dac_data), .sel({sel_hi, sel_lo}),
    .ctl_n({cs_n, wr_n, ld_n, a_n, b_n}), .dac_a(dac_a), .dac_b(dac_b),
    .pend(pend), .both_cnt(both_cnt), .load_cnt(load_cnt)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // ---------------------------------------------
  // Shared tasks
  // ---------------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rq, output logic err);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      mismatches++;
      results();
    end
    rq = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, q, e);
    check(q, exp);
  endtask

  // Extra cycles cover the model's sampling lag
  task automatic wait_idle;
    int n;
    n = 0;
    do begin
      apb(1'b0, `OFS_STATUS, 32'h0, q, e);
      n++;
    end while (q[0] !== 1'b0 && n < 40);
    if (q[0] !== 1'b0) begin
      mismatches++;
      results();
    end
    repeat (4) @(posedge clk);
  endtask

  // ---------------------------------------------
  // Scenarios
  // ---------------------------------------------
  task automatic t_reset;
    check({27'h0, cs_n, wr_n, ld_n, a_n, b_n}, 32'h1f);
    rchk(`OFS_CTRL, 32'h0);
    rchk(`OFS_CODE_A, 32'h0);
    rchk(`OFS_CODE_B, 32'h0);
    rchk(`OFS_STATUS, 32'h0);
    rchk(`OFS_CMD, 32'h0);
    apb(1'b0, 8'h14, 32'h0, q, e);
    check({31'h0, e}, 32'h1);
    check(q, 32'h0);
    apb(1'b1, 8'h20, 32'h5, q, e);
    check({31'h0, e}, 32'h1);
    $display("test reset done");
  endtask

  task automatic t_byte;
    wreg(`OFS_CODE_A, 32'ha5c);
    wreg(`OFS_CODE_B, 32'h3e1);
    wreg(`OFS_CMD, 32'h7);
    wreg(`OFS_CODE_A, 32'h111);
    apb(1'b0, `OFS_STATUS, 32'h0, q, e);
    check(q & 32'h3, 32'h3);
    wait_idle();
    check({20'h0, dac_a}, 32'ha5c);
    check({20'h0, dac_b}, 32'h3e1);
    rchk(`OFS_CODE_A, 32'ha5c);
    wreg(`OFS_STATUS, 32'h2);
    rchk(`OFS_STATUS, 32'h0);
    wreg(`OFS_CODE_A, 32'h5a7);
    wreg(`OFS_CMD, 32'h1);
    wait_idle();
    check({20'h0, pend[11:0]}, 32'h5a7);
    check({20'h0, dac_a}, 32'ha5c);
    wreg(`OFS_CMD, 32'h4);
    wait_idle();
    check({20'h0, dac_a}, 32'h5a7);
    check({20'h0, dac_b}, 32'h3e1);
    check({24'h0, load_cnt}, 32'h2);
    $display("test byte mode done");
  endtask

  task automatic t_par;
    wreg(`OFS_CTRL, 32'h1);
    rchk(`OFS_CTRL, 32'h1);
    wreg(`OFS_CODE_A, 32'h800);
    wreg(`OFS_CODE_B, 32'h7ff);
    wreg(`OFS_CMD, 32'h3);
    wait_idle();
    check({20'h0, dac_a}, 32'h800);
    check({20'h0, dac_b}, 32'h7ff);
    check({24'h0, both_cnt}, 32'h0);
    wreg(`OFS_CODE_B, 32'h800);
    wreg(`OFS_CMD, 32'h3);
    wait_idle();
    check({20'h0, dac_b}, 32'h800);
    check({24'h0, both_cnt}, 32'h1);
    wreg(`OFS_CODE_A, 32'h0ff);
    wreg(`OFS_CMD, 32'h1);
    wait_idle();
    check({8'h0, dac_a, dac_b}, {8'h0, 12'h0ff, 12'h800});
    wreg(`OFS_CODE_B, 32'hf00);
    wreg(`OFS_CMD, 32'h2);
    wait_idle();
    check({8'h0, dac_a, dac_b}, {8'h0, 12'h0ff, 12'hf00});
    wreg(`OFS_CMD, 32'h4);
    wait_idle();
    check({24'h0, load_cnt}, 32'h2);
    check({8'h0, pend}, {8'h0, 12'h3e1, 12'h5a7});
    $display("test parallel mode done");
  endtask

  initial begin
    mismatches = 0;
    checks_done = 0;
    rstn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (12) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset();
    t_byte();
    t_par();
    results();
  end
endmodule

`default_nettype wire

//--- verilog/dac_host.sv
`timescale 1ns/10ps
`default_nettype none
`include "dac_host_defs.svh"

module dac_host
  import dac_host_pkg::*;
(
  input  wire logic        CLK,                     // Core clock, 10 MHz
  input  wire logic        RSTN,                    // Async reset, active low
  input  wire logic        PSEL,                    // APB select
  input  wire logic        PENABLE,                 // APB access phase
  input  wire logic        PWRITE,                  // APB direction
  input  wire logic [7:0]  PADDR,                   // APB byte address
  input  wire logic [31:0] PWDATA,                  // APB write data
  output logic      [31:0] PRDATA,                  // APB read data
  output logic             PREADY,                  // APB ready
  output logic             PSLVERR,                 // APB error, unmapped
  output logic      [11:0] DAC_DATA,                // Converter data lines
  output logic             LATCH_SELECT_LOW,        // Latch address, low bit
  output logic             LATCH_SELECT_HIGH,       // Latch address, high bit
  output logic             CHIP_SELECT_N,           // Byte mode chip select
  output logic             WRITE_STROBE_N,          // Shared write strobe
  output logic             CONVERTER_LOAD_STROBE_N, // Byte mode load strobe
  output logic             CHANNEL_A_SELECT_N,      // Parallel mode select A
  output logic             CHANNEL_B_SELECT_N       // Parallel mode select B
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge CLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_meta_r <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n      <= rst_meta_r;
    end
  end

  // ---------------------------------------------------------------
  // Phase timer
  // ---------------------------------------------------------------
  host_state_type q;
  host_state_type d;
  logic           t_start;
  logic [3:0]     t_len;
  logic           t_done;

  phase_timer u_timer (
    .clk     (CLK),
    .rst_n   (rst_n),
    .start   (t_start),
    .len     (t_len),
    .expired (t_done)
  );

  function automatic logic [1:0] first_step(input logic [3:0] p);
    if (p[0]) begin
      return 2'h0;
    end else if (p[1]) begin
      return 2'h1;
    end else if (p[2]) begin
      return 2'h2;
    end
    return 2'h3;
  endfunction

  // ---------------------------------------------------------------
  // Bus decode and sequencer
  // ---------------------------------------------------------------
  logic        busy;
  logic        wr_acc;
  logic        rd_setup;
  logic        mapped;
  logic [3:0]  rest;
  logic [11:0] cur_code;
  logic        active;

  assign busy     = (q.state != ST_IDLE);
  assign wr_acc   = PSEL && PENABLE && PWRITE;
  assign rd_setup = PSEL && !PENABLE && !PWRITE;
  assign mapped   = (PADDR == `OFS_CTRL) || (PADDR == `OFS_CODE_A) ||
                    (PADDR == `OFS_CODE_B) || (PADDR == `OFS_CMD) ||
                    (PADDR == `OFS_STATUS);
  assign rest     = q.pend & ~(4'h1 << q.step);

  always_comb begin
    d        = q;
    t_start  = 1'b0;
    t_len    = 4'(`SETUP_CYC);
    cur_code = 12'h000;
    active   = 1'b0;

    // Read data registered in setup so the access phase needs no wait
    if (rd_setup) begin
      d.prdata = 32'h0000_0000;
      case (PADDR)
        `OFS_CTRL:   d.prdata[`CTRL_PAR_BIT] = q.ctrl_par;
        `OFS_CODE_A: d.prdata[`CODE_MSB:0] = q.code_a;
        `OFS_CODE_B: d.prdata[`CODE_MSB:0] = q.code_b;
        `OFS_STATUS: begin
          d.prdata[`STAT_BUSY_BIT]              = busy;
          d.prdata[`STAT_REFUSE_BIT]            = q.refused;
          d.prdata[`STAT_PEND_LSB+3:`STAT_PEND_LSB] = q.pend;
        end
        default:     d.prdata = 32'h0000_0000;
      endcase
    end

    // Settings are frozen while a sequence runs, so pins stay coherent
    if (wr_acc) begin
      case (PADDR)
        `OFS_CTRL: begin
          if (busy) begin
            d.refused = 1'b1;
          end else begin
            d.ctrl_par = PWDATA[`CTRL_PAR_BIT];
          end
        end
        `OFS_CODE_A: begin
          if (busy) begin
            d.refused = 1'b1;
          end else begin
            d.code_a = PWDATA[`CODE_MSB:0];
          end
        end
        `OFS_CODE_B: begin
          if (busy) begin
            d.refused = 1'b1;
          end else begin
            d.code_b = PWDATA[`CODE_MSB:0];
          end
        end
        `OFS_CMD: begin
          if (busy) begin
            d.refused = 1'b1;
          end else if (q.ctrl_par) begin
            d.pend    = {1'b0, PWDATA[`CMD_GO_B_BIT], 1'b0, PWDATA[`CMD_GO_A_BIT]};
            d.both    = PWDATA[`CMD_GO_A_BIT] && PWDATA[`CMD_GO_B_BIT] &&
                        (q.code_a == q.code_b);
            d.do_load = 1'b0;
            if (d.both) begin
              d.pend[2] = 1'b0;
            end
          end else begin
            d.pend    = {PWDATA[`CMD_GO_B_BIT], PWDATA[`CMD_GO_B_BIT],
                         PWDATA[`CMD_GO_A_BIT], PWDATA[`CMD_GO_A_BIT]};
            d.both    = 1'b0;
            d.do_load = PWDATA[`CMD_LOAD_BIT];
          end
          if (!busy && d.pend != 4'h0) begin
            d.state = ST_SETUP;
            d.step  = first_step(d.pend);
            t_start = 1'b1;
          end else if (!busy && d.do_load) begin
            d.state = ST_LOAD;
            t_start = 1'b1;
            t_len   = 4'(`LOAD_CYC);
          end
        end
        `OFS_STATUS: begin
          if (PWDATA[`STAT_REFUSE_BIT]) begin
            d.refused = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end

    case (q.state)
      ST_SETUP: begin
        if (t_done) begin
          d.state = ST_STROBE;
          t_start = 1'b1;
          t_len   = 4'(`STROBE_CYC);
        end
      end
      ST_STROBE: begin
        if (t_done) begin
          d.state = ST_HOLD;
          t_start = 1'b1;
          t_len   = 4'(`HOLD_CYC);
        end
      end
      ST_HOLD: begin
        if (t_done) begin
          d.pend = rest;
          if (rest != 4'h0) begin
            d.state = ST_SETUP;
            d.step  = first_step(rest);
            t_start = 1'b1;
          end else if (q.do_load) begin
            d.state = ST_LOAD;
            t_start = 1'b1;
            t_len   = 4'(`LOAD_CYC);
          end else begin
            d.state = ST_IDLE;
            d.both  = 1'b0;
          end
        end
      end
      ST_LOAD: begin
        if (t_done) begin
          d.state   = ST_IDLE;
          d.do_load = 1'b0;
        end
      end
      default: begin
      end
    endcase

    // Pins follow the next phase, so they leave flip-flops aligned with it
    active   = (d.state == ST_SETUP) || (d.state == ST_STROBE) ||
               (d.state == ST_HOLD);
    cur_code = d.step[1] ? d.code_b : d.code_a;
    d.wr_n   = (d.state != ST_STROBE);
    d.converter_load_strobe_n_n = d.ctrl_par || (d.state != ST_LOAD);
    if (d.ctrl_par) begin
      d.dac_data = active ? cur_code : 12'h000;
      d.cs_n     = 1'b1;
      d.sel_low  = 1'b0;
      d.sel_high = 1'b0;
      d.a_n      = !(active && d.step == 2'h0);
      d.b_n      = !(active && (d.step == 2'h2 || d.both));
    end else begin
      d.cs_n     = !active;
      d.sel_low  = active && d.step[0];
      d.sel_high = active && d.step[1];
      d.a_n      = 1'b1;
      d.b_n      = 1'b1;
      if (!active) begin
        d.dac_data = 12'h000;
      end else if (d.step[0]) begin
        d.dac_data = {8'h00, cur_code[11:8]};
      end else begin
        d.dac_data = {4'h0, cur_code[7:0]};
      end
    end
  end

  always_ff @(posedge CLK or negedge rst_n) begin
    if (!rst_n) begin
      q          <= '0;
      q.ctrl_par <= `RST_CTRL_PAR;
      q.code_a   <= `RST_CODE;
      q.code_b   <= `RST_CODE;
      q.state    <= ST_IDLE;
      q.cs_n     <= 1'b1;
      q.wr_n     <= 1'b1;
      q.converter_load_strobe_n_n   <= 1'b1;
      q.a_n      <= 1'b1;
      q.b_n      <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign PRDATA                  = q.prdata;
  assign PREADY                  = 1'b1;
  assign PSLVERR                 = PSEL && PENABLE && !mapped;
  assign DAC_DATA                = q.dac_data;
  assign LATCH_SELECT_LOW        = q.sel_low;
  assign LATCH_SELECT_HIGH       = q.sel_high;
  assign CHIP_SELECT_N           = q.cs_n;
  assign WRITE_STROBE_N          = q.wr_n;
  assign CONVERTER_LOAD_STROBE_N = q.converter_load_strobe_n_n;
  assign CHANNEL_A_SELECT_N      = q.a_n;
  assign CHANNEL_B_SELECT_N      = q.b_n;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!rst_n);

  property p_low_byte;
    !WRITE_STROBE_N && !q.ctrl_par && !LATCH_SELECT_LOW |->
      DAC_DATA == {4'h0, (LATCH_SELECT_HIGH ? q.code_b[7:0] : q.code_a[7:0])};
  endproperty
  a_low_byte: assert property (p_low_byte) else $error("low byte data wrong");

  property p_high_nib;
    !WRITE_STROBE_N && !q.ctrl_par && LATCH_SELECT_LOW |->
      DAC_DATA == {8'h00, (LATCH_SELECT_HIGH ? q.code_b[11:8] : q.code_a[11:8])};
  endproperty
  a_high_nib: assert property (p_high_nib) else $error("high nibble data wrong");

  property p_strobe_framed;
    $fell(WRITE_STROBE_N) && !q.ctrl_par |->
      !$past(CHIP_SELECT_N) && !CHIP_SELECT_N;
  endproperty
  a_strobe_framed: assert property (p_strobe_framed) else $error("strobe without chip select");

  property p_stable_under_strobe;
    !WRITE_STROBE_N && !$past(WRITE_STROBE_N) |->
      $stable({DAC_DATA, LATCH_SELECT_LOW, LATCH_SELECT_HIGH, CHANNEL_A_SELECT_N, CHANNEL_B_SELECT_N});
  endproperty
  a_stable_under_strobe: assert property (p_stable_under_strobe) else $error("pins moved under strobe");

  property p_par_select;
    !WRITE_STROBE_N && q.ctrl_par |->
      CHIP_SELECT_N && (!CHANNEL_A_SELECT_N || !CHANNEL_B_SELECT_N);
  endproperty
  a_par_select: assert property (p_par_select) else $error("parallel strobe without select");

  property p_par_data;
    !WRITE_STROBE_N && q.ctrl_par |->
      DAC_DATA == (!CHANNEL_A_SELECT_N ? q.code_a : q.code_b);
  endproperty
  a_par_data: assert property (p_par_data) else $error("parallel data word wrong");

  property p_strobe_width;
    $fell(WRITE_STROBE_N) |-> !WRITE_STROBE_N[*2] ##1 (WRITE_STROBE_N && $stable(DAC_DATA));
  endproperty
  a_strobe_width: assert property (p_strobe_width) else $error("strobe width or hold wrong");

  property p_load_quiet;
    $fell(CONVERTER_LOAD_STROBE_N) |->
      CHIP_SELECT_N && WRITE_STROBE_N && !q.ctrl_par ##1 !CONVERTER_LOAD_STROBE_N ##1 CONVERTER_LOAD_STROBE_N;
  endproperty
  a_load_quiet: assert property (p_load_quiet) else $error("load strobe misplaced");

  property p_busy_bounded;
    $rose(busy) |-> ##[1:40] !busy;
  endproperty
  a_busy_bounded: assert property (p_busy_bounded) else $error("sequence did not finish");

  c_byte_load: cover property ($fell(CONVERTER_LOAD_STROBE_N) && $past(q.pend) == 4'h0);
  c_par_both: cover property (!WRITE_STROBE_N && !CHANNEL_A_SELECT_N && !CHANNEL_B_SELECT_N);
  c_refused: cover property ($rose(q.refused));

endmodule

`default_nettype wire

//--- verilog/phase_timer.sv
`timescale 1ns/10ps
`default_nettype none

module phase_timer
  import dac_host_pkg::*;
(
  input  wire logic       clk,     // Core clock
  input  wire logic       rst_n,   // Synchronised reset, active low
  input  wire logic       start,   // Load a new phase length
  input  wire logic [3:0] len,     // Phase length in cycles, at least 1
  output logic            expired  // Last cycle of the phase
);

  timer_state_type q;
  timer_state_type d;

  always_comb begin
    d = q;
    if (start) begin
      d.cnt = 4'(len - 4'h1);
    end else if (q.cnt != 4'h0) begin
      d.cnt = 4'(q.cnt - 4'h1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign expired = (q.cnt == 4'h0);

endmodule

`default_nettype wire
